// ===== spcsm_pkg.sv
// constants, state encoding and timing figures of the clock-stop serial port
// assumes the cpu clock is the only clock and the pins are sampled on it
package spcsm_pkg;

  // cpu clock period; h is half of it
  localparam int REF_CLK_PERIOD_NS = 50;
  localparam int H_NS              = REF_CLK_PERIOD_NS / 2;
  localparam int TWO_H_CYCLES      = (2 * H_NS) / REF_CLK_PERIOD_NS;

  // widths fixed at the documented values
  localparam int WORD_BITS = 8;
  localparam int DIV_W     = 8;
  localparam int LEN_W     = DIV_W + 1;
  localparam int CNT_W     = 4;
  localparam int GAP_W     = 10;

  // mode settings accepted by the block
  localparam logic [1:0]       CLK_STOP_DELAYED = 2'h3;
  localparam logic             CLK_POL_HIGH     = 1'h1;
  localparam logic             SYNC_POL_LOW     = 1'h1;
  localparam logic [3:0]       MASTER_DIRS      = 4'hC;
  localparam logic [3:0]       SLAVE_DIRS       = 4'h0;
  localparam logic             SLAVE_SRC_CPU    = 1'h1;
  localparam logic [DIV_W-1:0] SLAVE_DIV        = 8'h01;
  localparam logic [DIV_W-1:0] MIN_DIV          = 8'h01;

  // counts and reset levels
  localparam logic [CNT_W-1:0]     LAST_BIT   = 4'h8;
  localparam logic [CNT_W-1:0]     ONE_BIT    = 4'h1;
  localparam logic [LEN_W-1:0]     LEN_ONE    = 9'h001;
  localparam logic [GAP_W-1:0]     GAP_ONE    = 10'h001;
  localparam logic                 PIN_IDLE   = 1'h1;
  localparam logic [WORD_BITS-1:0] WORD_ZERO  = 8'h00;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_TRAIL = 3'b011,
    ST_SLAVE = 3'b100
  } spcsm_state_e;

endpackage

// ===== spcsm_clkgen.sv
// sample-rate clock generator: cpu clock divided by divide + 1, with a divide of 0 run as 1
// assumes divide stays stable while run_i is high
module spcsm_clkgen
(
  input  wire logic                            clk_i,
  input  wire logic                            rstn_i,
  input  wire logic                            run_i,
  input  wire logic [spcsm_pkg::DIV_W-1:0]     divide_i,
  output logic                                 level_o,
  output logic                                 rise_o,
  output logic                                 fall_o,
  output logic      [spcsm_pkg::LEN_W-1:0]     c_len_o,
  output logic      [spcsm_pkg::LEN_W-1:0]     d_len_o,
  output logic      [spcsm_pkg::LEN_W-1:0]     t_len_o
);

  logic [spcsm_pkg::DIV_W-1:0] div_eff;
  logic [spcsm_pkg::LEN_W-1:0] half_cnt;
  logic [spcsm_pkg::LEN_W-1:0] cnt_reg;

  // divide 0 would need a half-cycle phase, so it runs as 1
  assign div_eff  = (divide_i < spcsm_pkg::MIN_DIV) ? spcsm_pkg::MIN_DIV : divide_i;
  assign half_cnt = {1'b0, div_eff} + spcsm_pkg::LEN_ONE;
  // period, low and high time in cpu cycles
  assign t_len_o  = spcsm_pkg::LEN_W'(half_cnt * spcsm_pkg::TWO_H_CYCLES);
  assign c_len_o  = spcsm_pkg::LEN_W'((half_cnt >> 1) * spcsm_pkg::TWO_H_CYCLES);
  assign d_len_o  = t_len_o - c_len_o;

  // phase counter; one-cycle pulses mark each edge of the divided clock
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_reg <= '0;
      level_o <= spcsm_pkg::PIN_IDLE;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_reg <= '0;
      level_o <= spcsm_pkg::PIN_IDLE;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end
    else
    begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      // >= so a shortened divide cannot strand the counter
      if (level_o && (cnt_reg >= d_len_o - spcsm_pkg::LEN_ONE))
      begin
        level_o <= 1'b0;
        cnt_reg <= '0;
        fall_o  <= 1'b1;
      end
      else if (!level_o && (cnt_reg >= c_len_o - spcsm_pkg::LEN_ONE))
      begin
        level_o <= 1'b1;
        cnt_reg <= '0;
        rise_o  <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + spcsm_pkg::LEN_ONE;
      end
    end
  end

endmodule

// ===== spcsm_spi_clock_stop.sv
// clock-stop spi port, master or slave, delayed-clock mode with clock polarity 1
// assumes all pin inputs are synchronous to REF_CLK_I and settings are static during a frame
// Operation
// - every slave setup runs the internal sample clock at half the cpu clock, source select and divide both 1.
// - the slave enable goes low before the serial clock moves, and the transfer then starts on the clock.
// - as master the serial clock period is (1 + divide) times 2h, with a divide of 0 run as 1.
// - the clock low time is half the period for odd or zero divide, else divide/2 times 2h.
// - the clock high time is half the period for odd or zero divide, else (divide/2 + 1) times 2h.
// - both sync polarity bits are 1, and as master the transmit sync pin is an active-low slave enable.
// - as slave the active-low enables on both sync pins are inverted before internal use.
// - as master the transmit clock and sync directions are outputs, the receive ones inputs.
// - as slave all four clock and sync directions are inputs.
// - received data is sampled on the falling edge of the serial clock.
// - transmit data changes after each rising edge of the serial clock.
// - as master the enable goes low one full period before the first falling clock edge.
// - as master the enable stays low for one high time after the last rising edge.
// - the data output goes to high impedance right after the final rising clock edge.
// - as slave the first bit is driven in answer to the enable going low, before any clock edge.
// - h is half the cpu clock period.
module spcsm_spi_clock_stop
(
  input  wire logic                                REF_CLK_I,
  input  wire logic                                RSTN_I,
  input  wire logic [1:0]                          CLOCK_STOP_SELECT_I,
  input  wire logic                                TX_CLOCK_POLARITY_I,
  input  wire logic                                TX_SYNC_POLARITY_I,
  input  wire logic                                RX_SYNC_POLARITY_I,
  input  wire logic                                TX_CLOCK_DIR_I,
  input  wire logic                                TX_SYNC_DIR_I,
  input  wire logic                                RX_CLOCK_DIR_I,
  input  wire logic                                RX_SYNC_DIR_I,
  input  wire logic                                SAMPLE_CLOCK_SOURCE_SEL_I,
  input  wire logic [spcsm_pkg::DIV_W-1:0]         SAMPLE_CLOCK_DIVIDE_I,
  input  wire logic                                START_I,
  input  wire logic [spcsm_pkg::WORD_BITS-1:0]     TX_DATA_I,
  output logic      [spcsm_pkg::WORD_BITS-1:0]     RX_DATA_O,
  output logic                                     RX_VALID_O,
  output logic                                     BUSY_O,
  output logic                                     CONFIG_ERROR_O,
  input  wire logic                                TX_SERIAL_CLOCK_PIN_I,
  output logic                                     TX_SERIAL_CLOCK_PIN_O,
  output logic                                     TX_SERIAL_CLOCK_PIN_OE_O,
  input  wire logic                                TX_FRAME_SYNC_PIN_I,
  output logic                                     TX_FRAME_SYNC_PIN_O,
  output logic                                     TX_FRAME_SYNC_PIN_OE_O,
  input  wire logic                                RX_FRAME_SYNC_PIN_I,
  output logic                                     SERIAL_DATA_OUT_PIN_O,
  output logic                                     SERIAL_DATA_OUT_PIN_OE_O,
  input  wire logic                                SERIAL_DATA_IN_PIN_I
);

  spcsm_pkg::spcsm_state_e           state_reg;
  logic [3:0]                        dirs;
  logic                              common_ok;
  logic                              master_cfg;
  logic                              slave_cfg;
  logic                              gen_level;
  logic                              gen_rise;
  logic                              gen_fall;
  logic [spcsm_pkg::LEN_W-1:0]       c_len;
  logic [spcsm_pkg::LEN_W-1:0]       d_len;
  logic [spcsm_pkg::LEN_W-1:0]       t_len;
  logic                              pending_reg;
  logic [spcsm_pkg::WORD_BITS-1:0]   hold_reg;
  logic [spcsm_pkg::WORD_BITS-1:0]   tx_sh_reg;
  logic [spcsm_pkg::WORD_BITS-1:0]   rx_sh_reg;
  logic [spcsm_pkg::CNT_W-1:0]       bit_cnt_reg;
  logic                              sl_en_now;
  logic                              sl_rx_en;
  logic                              sl_en_reg;
  logic                              sl_sclk_reg;
  logic                              sl_start;
  logic                              sl_stop;
  logic                              sl_fall;
  logic                              sl_rise;
  logic                              abort;
  logic                              sample_strobe;
  logic                              first_drive;
  logic                              shift_out;
  logic                              release_out;
  logic                              frame_done;
  logic                              last_bit;

  // mode decode from the configuration pins
  assign dirs       = {TX_CLOCK_DIR_I, TX_SYNC_DIR_I, RX_CLOCK_DIR_I, RX_SYNC_DIR_I};
  assign common_ok  = (CLOCK_STOP_SELECT_I == spcsm_pkg::CLK_STOP_DELAYED)
                   && (TX_CLOCK_POLARITY_I == spcsm_pkg::CLK_POL_HIGH)
                   && (TX_SYNC_POLARITY_I == spcsm_pkg::SYNC_POL_LOW)
                   && (RX_SYNC_POLARITY_I == spcsm_pkg::SYNC_POL_LOW);
  assign master_cfg = common_ok && (dirs == spcsm_pkg::MASTER_DIRS);
  assign slave_cfg  = common_ok && (dirs == spcsm_pkg::SLAVE_DIRS)
                   && (SAMPLE_CLOCK_SOURCE_SEL_I == spcsm_pkg::SLAVE_SRC_CPU)
                   && (SAMPLE_CLOCK_DIVIDE_I == spcsm_pkg::SLAVE_DIV);

  // divided clock: master edges, and the cpu/2 sampling tick of the slave
  spcsm_clkgen u_clkgen
  (
    .clk_i    (REF_CLK_I),
    .rstn_i   (RSTN_I),
    .run_i    (master_cfg || slave_cfg),
    .divide_i (SAMPLE_CLOCK_DIVIDE_I),
    .level_o  (gen_level),
    .rise_o   (gen_rise),
    .fall_o   (gen_fall),
    .c_len_o  (c_len),
    .d_len_o  (d_len),
    .t_len_o  (t_len)
  );

  // slave pins are looked at once per tick; enables are active low outside
  assign sl_en_now = !TX_FRAME_SYNC_PIN_I;
  assign sl_rx_en  = !RX_FRAME_SYNC_PIN_I;
  assign sl_start  = slave_cfg && gen_fall && sl_en_now && !sl_en_reg;
  assign sl_stop   = gen_fall && !sl_en_now && sl_en_reg;
  assign sl_fall   = gen_fall && sl_en_now && sl_sclk_reg && !TX_SERIAL_CLOCK_PIN_I;
  assign sl_rise   = gen_fall && sl_en_now && !sl_sclk_reg && TX_SERIAL_CLOCK_PIN_I;

  // frame strobes shared by both roles
  assign last_bit      = (bit_cnt_reg == spcsm_pkg::LAST_BIT);
  assign abort         = (state_reg != spcsm_pkg::ST_IDLE) && !master_cfg && !slave_cfg;
  assign sample_strobe = ((state_reg == spcsm_pkg::ST_LEAD || state_reg == spcsm_pkg::ST_SHIFT) && gen_fall)
                      || (state_reg == spcsm_pkg::ST_SLAVE && sl_fall && sl_rx_en && !last_bit);
  assign first_drive   = (state_reg == spcsm_pkg::ST_LEAD && gen_rise)
                      || (state_reg == spcsm_pkg::ST_IDLE && sl_start);
  assign shift_out     = ((state_reg == spcsm_pkg::ST_SHIFT && gen_rise)
                      || (state_reg == spcsm_pkg::ST_SLAVE && sl_rise)) && !last_bit;
  assign release_out   = ((state_reg == spcsm_pkg::ST_SHIFT && gen_rise)
                      || (state_reg == spcsm_pkg::ST_SLAVE && sl_rise)) && last_bit
                      || (state_reg == spcsm_pkg::ST_SLAVE && sl_stop) || abort;
  assign frame_done    = (state_reg == spcsm_pkg::ST_TRAIL && gen_fall && !abort)
                      || (state_reg == spcsm_pkg::ST_SLAVE && sl_stop && last_bit);

  // frame sequencer; master frames align to a divided-clock falling edge
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_reg <= spcsm_pkg::ST_IDLE;
    end
    else if (abort)
    begin
      state_reg <= spcsm_pkg::ST_IDLE;
    end
    else
    begin
      case (state_reg)
        spcsm_pkg::ST_IDLE:
        begin
          if (master_cfg && pending_reg && gen_fall)
            state_reg <= spcsm_pkg::ST_LEAD;
          else if (sl_start)
            state_reg <= spcsm_pkg::ST_SLAVE;
        end
        spcsm_pkg::ST_LEAD:
          if (gen_fall)
            state_reg <= spcsm_pkg::ST_SHIFT;
        spcsm_pkg::ST_SHIFT:
          if (gen_rise && last_bit)
            state_reg <= spcsm_pkg::ST_TRAIL;
        spcsm_pkg::ST_TRAIL:
          if (gen_fall)
            state_reg <= spcsm_pkg::ST_IDLE;
        spcsm_pkg::ST_SLAVE:
          if (sl_stop)
            state_reg <= spcsm_pkg::ST_IDLE;
        default:
          state_reg <= spcsm_pkg::ST_IDLE;
      endcase
    end
  end
  // start request and transmit word; a start outside ST_IDLE is ignored
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      pending_reg <= 1'b0;
      hold_reg    <= spcsm_pkg::WORD_ZERO;
    end
    else if (state_reg == spcsm_pkg::ST_IDLE && START_I)
    begin
      pending_reg <= 1'b1;
      hold_reg    <= TX_DATA_I;
    end
    else if (state_reg == spcsm_pkg::ST_LEAD || !master_cfg)
    begin
      pending_reg <= 1'b0;
    end
  end
  // slave pin history, taken on the cpu/2 tick only
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sl_en_reg   <= 1'b0;
      sl_sclk_reg <= spcsm_pkg::PIN_IDLE;
    end
    else if (gen_fall && slave_cfg)
    begin
      sl_en_reg   <= sl_en_now;
      sl_sclk_reg <= TX_SERIAL_CLOCK_PIN_I;
    end
    else if (!slave_cfg)
    begin
      sl_en_reg   <= 1'b0;
    end
  end
  // bit counter counts samples taken in the frame
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      bit_cnt_reg <= '0;
    else if (state_reg == spcsm_pkg::ST_IDLE)
      bit_cnt_reg <= '0;
    else if (sample_strobe)
      bit_cnt_reg <= bit_cnt_reg + spcsm_pkg::ONE_BIT;
  end
  // transmit shifter, msb first
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tx_sh_reg                <= spcsm_pkg::WORD_ZERO;
      SERIAL_DATA_OUT_PIN_O    <= 1'b0;
      SERIAL_DATA_OUT_PIN_OE_O <= 1'b0;
    end
    else if (release_out)
    begin
      SERIAL_DATA_OUT_PIN_OE_O <= 1'b0;
    end
    else if (first_drive)
    begin
      // slave drives on the enable alone, no clock edge needed
      tx_sh_reg                <= hold_reg;
      SERIAL_DATA_OUT_PIN_O    <= hold_reg[spcsm_pkg::WORD_BITS-1];
      SERIAL_DATA_OUT_PIN_OE_O <= 1'b1;
    end
    else if (shift_out)
    begin
      tx_sh_reg             <= {tx_sh_reg[spcsm_pkg::WORD_BITS-2:0], 1'b0};
      SERIAL_DATA_OUT_PIN_O <= tx_sh_reg[spcsm_pkg::WORD_BITS-2];
    end
  end
  // receive shifter and word hand-off
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rx_sh_reg  <= spcsm_pkg::WORD_ZERO;
      RX_DATA_O  <= spcsm_pkg::WORD_ZERO;
      RX_VALID_O <= 1'b0;
    end
    else
    begin
      RX_VALID_O <= frame_done;
      if (sample_strobe)
        rx_sh_reg <= {rx_sh_reg[spcsm_pkg::WORD_BITS-2:0], SERIAL_DATA_IN_PIN_I};
      if (frame_done)
        RX_DATA_O <= rx_sh_reg;
    end
  end
  // master clock and enable pins; clock idles high with polarity 1
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      TX_SERIAL_CLOCK_PIN_O <= spcsm_pkg::PIN_IDLE;
      TX_FRAME_SYNC_PIN_O   <= spcsm_pkg::PIN_IDLE;
    end
    else if (abort || state_reg == spcsm_pkg::ST_IDLE)
    begin
      TX_SERIAL_CLOCK_PIN_O <= spcsm_pkg::PIN_IDLE;
      // inverted frame sync: low while the frame runs
      TX_FRAME_SYNC_PIN_O   <= !(master_cfg && pending_reg && gen_fall);
    end
    else
    begin
      if ((state_reg == spcsm_pkg::ST_LEAD || state_reg == spcsm_pkg::ST_SHIFT) && gen_fall)
        TX_SERIAL_CLOCK_PIN_O <= 1'b0;
      else if (state_reg == spcsm_pkg::ST_SHIFT && gen_rise)
        TX_SERIAL_CLOCK_PIN_O <= 1'b1;
      if (state_reg == spcsm_pkg::ST_TRAIL && gen_fall)
        TX_FRAME_SYNC_PIN_O <= spcsm_pkg::PIN_IDLE;
    end
  end
  // pin directions and status
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      TX_SERIAL_CLOCK_PIN_OE_O <= 1'b0;
      TX_FRAME_SYNC_PIN_OE_O   <= 1'b0;
      BUSY_O                   <= 1'b0;
      CONFIG_ERROR_O           <= 1'b0;
    end
    else
    begin
      TX_SERIAL_CLOCK_PIN_OE_O <= master_cfg;
      TX_FRAME_SYNC_PIN_OE_O   <= master_cfg;
      BUSY_O                   <= pending_reg || (state_reg != spcsm_pkg::ST_IDLE);
      CONFIG_ERROR_O           <= !(master_cfg || slave_cfg);
    end
  end
  // helper for the checks: cycles since the clock or enable pin last moved
  logic [spcsm_pkg::GAP_W-1:0] gap_reg;
  logic                        prev_clk_reg;
  logic                        prev_sync_reg;
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      gap_reg       <= '0;
      prev_clk_reg  <= spcsm_pkg::PIN_IDLE;
      prev_sync_reg <= spcsm_pkg::PIN_IDLE;
    end
    else
    begin
      prev_clk_reg  <= TX_SERIAL_CLOCK_PIN_O;
      prev_sync_reg <= TX_FRAME_SYNC_PIN_O;
      if (TX_SERIAL_CLOCK_PIN_O != prev_clk_reg || TX_FRAME_SYNC_PIN_O != prev_sync_reg)
        gap_reg <= spcsm_pkg::GAP_ONE;
      else if (gap_reg != '1)
        gap_reg <= gap_reg + spcsm_pkg::GAP_ONE;
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  slave_tick_a: assert property (gen_fall && slave_cfg ##1 slave_cfg |-> !gen_fall ##1 gen_fall)
    else $error("slave sampling tick not at half the cpu rate");
  enable_first_a: assert property ($fell(TX_SERIAL_CLOCK_PIN_O) |-> !TX_FRAME_SYNC_PIN_O)
    else $error("serial clock moved while enable high");
  low_time_a: assert property ($rose(TX_SERIAL_CLOCK_PIN_O) |-> gap_reg == {1'b0, c_len})
    else $error("serial clock low time wrong");
  high_time_a: assert property ($fell(TX_SERIAL_CLOCK_PIN_O) && bit_cnt_reg > spcsm_pkg::ONE_BIT
                                |-> gap_reg == {1'b0, d_len})
    else $error("serial clock high time wrong");
  lead_time_a: assert property ($fell(TX_SERIAL_CLOCK_PIN_O) && bit_cnt_reg == spcsm_pkg::ONE_BIT
                                |-> gap_reg == {1'b0, t_len})
    else $error("enable to first falling edge is not one period");
  trail_time_a: assert property ($rose(TX_FRAME_SYNC_PIN_O) |-> gap_reg == {1'b0, d_len})
    else $error("enable release not one high time after last rise");
  sync_low_a: assert property (state_reg inside {spcsm_pkg::ST_LEAD, spcsm_pkg::ST_SHIFT}
                               |-> !TX_FRAME_SYNC_PIN_O && TX_FRAME_SYNC_PIN_OE_O)
    else $error("master enable not driven low during frame");
  master_dir_a: assert property (TX_SERIAL_CLOCK_PIN_OE_O |-> $past(master_cfg))
    else $error("clock pin driven outside master setup");
  slave_dir_a: assert property (state_reg == spcsm_pkg::ST_SLAVE
                                |-> !TX_SERIAL_CLOCK_PIN_OE_O && !TX_FRAME_SYNC_PIN_OE_O)
    else $error("slave drives clock or enable pin");
  sample_fall_a: assert property (sample_strobe && master_cfg |=> $fell(TX_SERIAL_CLOCK_PIN_O))
    else $error("master sample not on falling edge");
  data_rise_a: assert property (master_cfg && SERIAL_DATA_OUT_PIN_OE_O && $past(SERIAL_DATA_OUT_PIN_OE_O)
                                && $changed(SERIAL_DATA_OUT_PIN_O) |-> $rose(TX_SERIAL_CLOCK_PIN_O))
    else $error("master data changed off a rising edge");
  release_a: assert property ($fell(SERIAL_DATA_OUT_PIN_OE_O) && state_reg == spcsm_pkg::ST_TRAIL
                              |-> $rose(TX_SERIAL_CLOCK_PIN_O))
    else $error("data release not at final rising edge");
  slave_first_a: assert property (state_reg == spcsm_pkg::ST_SLAVE && $past(state_reg) == spcsm_pkg::ST_IDLE
                                  |-> SERIAL_DATA_OUT_PIN_OE_O && TX_SERIAL_CLOCK_PIN_I == sl_sclk_reg)
    else $error("slave first bit not driven on enable");

  master_frame_c: cover property (state_reg == spcsm_pkg::ST_TRAIL ##[1:600] RX_VALID_O);
  slave_frame_c: cover property (state_reg == spcsm_pkg::ST_SLAVE ##[1:1000] RX_VALID_O);
  even_div_c: cover property ($rose(TX_SERIAL_CLOCK_PIN_O) && c_len != d_len);
  config_err_c: cover property ($rose(CONFIG_ERROR_O));

endmodule

// ===== spcsm_slave_model.sv
// spi slave device facing the port in its master role
// assumes a clock idling high and an active-low enable
module spcsm_slave_model
(
  input  wire logic       sclk_i,
  input  wire logic       sel_n_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] word_i,
  output logic            miso_o,
  output logic      [7:0] got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx = 0;
  initial miso_o = 1'b0;
  // first bit answers the enable alone
  always @(negedge sel_n_i)
  begin
    idx = 7;
    miso_o = word_i[7];
  end
  // capture on the falling edge while selected
  always @(negedge sclk_i) if (!sel_n_i) got_o = {got_o[6:0], mosi_i};
  // next bit after each rising edge
  always @(posedge sclk_i)
  begin
    if (!sel_n_i && idx > 0)
    begin
      idx = idx - 1;
      miso_o = word_i[idx];
    end
  end
  // released line must not look like held data
  always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule

// ===== testbench.sv
// self-checking bench of the clock-stop spi port, master and slave roles
// assumes the slave model file is compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] CLOCK_STOP_SELECT_I = 2'h3;
  logic       TX_SYNC_POLARITY_I = 1;
  logic       REF_CLK_I = 0, RSTN_I = 0, START_I = 0, RX_FRAME_SYNC_PIN_I = 1, SAMPLE_CLOCK_SOURCE_SEL_I = 1;
  logic       TX_CLOCK_DIR_I = 0, TX_SYNC_DIR_I = 0, RX_CLOCK_DIR_I = 0, RX_SYNC_DIR_I = 0;
  logic [7:0] SAMPLE_CLOCK_DIVIDE_I = 8'h01, TX_DATA_I = 8'h00, RX_DATA_O, peer_word = 8'h00, got;
  logic       clk_drv = 1, sel_drv = 1, din_drv = 0, clk_q = 1, sel_q = 1, miso, RX_VALID_O, BUSY_O;
  logic       CONFIG_ERROR_O, TX_SERIAL_CLOCK_PIN_O, TX_SERIAL_CLOCK_PIN_OE_O, TX_FRAME_SYNC_PIN_O;
  logic       TX_FRAME_SYNC_PIN_OE_O, SERIAL_DATA_OUT_PIN_O, SERIAL_DATA_OUT_PIN_OE_O;
  int         n_errors = 0, checks = 0, run = 0, lead, lo_len, hi_len, trail, rises;
  // wire levels from both parties' enables
  wire TX_SERIAL_CLOCK_PIN_I = TX_SERIAL_CLOCK_PIN_OE_O ? TX_SERIAL_CLOCK_PIN_O : clk_drv;
  wire TX_FRAME_SYNC_PIN_I = TX_FRAME_SYNC_PIN_OE_O ? TX_FRAME_SYNC_PIN_O : sel_drv;
  wire SERIAL_DATA_IN_PIN_I = TX_CLOCK_DIR_I ? miso : din_drv;
  wire mosi = SERIAL_DATA_OUT_PIN_OE_O ? SERIAL_DATA_OUT_PIN_O : ~SERIAL_DATA_OUT_PIN_O;
  spcsm_spi_clock_stop i_dut
  (
    .REF_CLK_I, .RSTN_I, .CLOCK_STOP_SELECT_I, .TX_CLOCK_POLARITY_I(1'b1), .TX_SYNC_POLARITY_I,
    .RX_SYNC_POLARITY_I(1'b1), .TX_CLOCK_DIR_I, .TX_SYNC_DIR_I, .RX_CLOCK_DIR_I, .RX_SYNC_DIR_I,
    .SAMPLE_CLOCK_SOURCE_SEL_I, .SAMPLE_CLOCK_DIVIDE_I, .START_I, .TX_DATA_I, .RX_DATA_O, .RX_VALID_O,
    .BUSY_O, .CONFIG_ERROR_O, .TX_SERIAL_CLOCK_PIN_I, .TX_SERIAL_CLOCK_PIN_O, .TX_SERIAL_CLOCK_PIN_OE_O,
    .TX_FRAME_SYNC_PIN_I, .TX_FRAME_SYNC_PIN_O, .TX_FRAME_SYNC_PIN_OE_O, .RX_FRAME_SYNC_PIN_I,
    .SERIAL_DATA_OUT_PIN_O, .SERIAL_DATA_OUT_PIN_OE_O, .SERIAL_DATA_IN_PIN_I
  );
  spcsm_slave_model i_peer
  (
    .sclk_i(TX_SERIAL_CLOCK_PIN_I), .sel_n_i(TX_FRAME_SYNC_PIN_I), .mosi_i(mosi), .word_i(peer_word),
    .miso_o(miso), .got_o(got)
  );
  initial forever #25 REF_CLK_I = ~REF_CLK_I;
  // master phase lengths, sampled at the falling edge where settled
  always @(negedge REF_CLK_I)
  begin
    if (sel_q && !TX_FRAME_SYNC_PIN_O) {rises, run, lead} = '0;
    else if (!sel_q && TX_FRAME_SYNC_PIN_O) trail = run;
    else if (clk_q && !TX_SERIAL_CLOCK_PIN_O && lead == 0) {lead, run} = {run, 32'h0};
    else if (clk_q && !TX_SERIAL_CLOCK_PIN_O) {hi_len, run} = {run, 32'h0};
    else if (!clk_q && TX_SERIAL_CLOCK_PIN_O) {lo_len, run, rises} = {run, 32'h0, rises + 1};
    if (rises == 8 && !clk_q && TX_SERIAL_CLOCK_PIN_O) check(SERIAL_DATA_OUT_PIN_OE_O, 8'h00);
    sel_q = TX_FRAME_SYNC_PIN_O;
    clk_q = TX_SERIAL_CLOCK_PIN_O;
    run++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) $display("BAD %0t seen %h want %h", $time, seen, want);
    if (seen !== want) n_errors++;
  endtask
  // bounded wait for the received-word pulse
  task automatic wait_valid();
    int i;
    for (i = 0; i < 200 && RX_VALID_O !== 1'b1; i++) @(negedge REF_CLK_I);
    if (RX_VALID_O !== 1'b1)
    begin
      $display("BAD %0t timeout waiting for received word", $time);
      n_errors++;
      final_report();
    end
  endtask
  task automatic master_frame(input logic [7:0] div, input logic [7:0] word);
    int t;
    t = div + 1;
    {TX_CLOCK_DIR_I, TX_SYNC_DIR_I, SAMPLE_CLOCK_DIVIDE_I, peer_word, TX_DATA_I} = {2'b11, div, ~word, word};
    @(negedge REF_CLK_I) START_I = 1;
    @(negedge REF_CLK_I) START_I = 0;
    @(negedge REF_CLK_I) check(BUSY_O, 8'h01);
    wait_valid();
    // one more edge so the phase monitor has surely logged the enable release
    @(negedge REF_CLK_I) check({BUSY_O, RX_VALID_O}, 8'h00);
    check({TX_SERIAL_CLOCK_PIN_OE_O, TX_FRAME_SYNC_PIN_OE_O}, 8'h03);
    check(RX_DATA_O, ~word);
    check(got, word);
    check(lead, t);
    check(lo_len, div[0] ? t / 2 : div / 2);
    check(hi_len, div[0] ? t / 2 : div / 2 + 1);
    check(trail, div[0] ? t / 2 : div / 2 + 1);
  endtask
  task automatic slave_frame(input logic [7:0] word, input logic [7:0] din);
    logic [7:0] seen;
    {TX_CLOCK_DIR_I, TX_SYNC_DIR_I, SAMPLE_CLOCK_DIVIDE_I, TX_DATA_I, START_I} = {2'b00, 8'h01, word, 1'b1};
    @(negedge REF_CLK_I) START_I = 0;
    check({CONFIG_ERROR_O, TX_SERIAL_CLOCK_PIN_OE_O, TX_FRAME_SYNC_PIN_OE_O}, 8'h00);
    {sel_drv, RX_FRAME_SYNC_PIN_I} = 2'b00; // enable low before the first clock edge
    repeat (4) @(negedge REF_CLK_I);
    check(SERIAL_DATA_OUT_PIN_OE_O, 8'h01);
    for (int i = 7; i >= 0; i--)
    begin
      {seen[i], din_drv, clk_drv} = {SERIAL_DATA_OUT_PIN_O, din[i], 1'b0};
      repeat (4) @(negedge REF_CLK_I);
      clk_drv = 1;
      repeat (4) @(negedge REF_CLK_I);
    end
    check(SERIAL_DATA_OUT_PIN_OE_O, 8'h00);
    check(seen, word);
    {sel_drv, RX_FRAME_SYNC_PIN_I, din_drv} = {2'b11, ~din[0]};
    wait_valid();
    check(RX_DATA_O, din);
  endtask
  // settings outside both roles must be flagged
  task automatic bad_settings();
    {SAMPLE_CLOCK_DIVIDE_I, CLOCK_STOP_SELECT_I} = {8'h02, 2'h3};
    repeat (2) @(negedge REF_CLK_I);
    check(CONFIG_ERROR_O, 8'h01);
    {SAMPLE_CLOCK_DIVIDE_I, CLOCK_STOP_SELECT_I} = {8'h01, 2'h2};
    repeat (2) @(negedge REF_CLK_I);
    check(CONFIG_ERROR_O, 8'h01);
    {CLOCK_STOP_SELECT_I, TX_SYNC_POLARITY_I} = {2'h3, 1'b0};
    repeat (2) @(negedge REF_CLK_I);
    check(CONFIG_ERROR_O, 8'h01);
    TX_SYNC_POLARITY_I = 1;
    repeat (2) @(negedge REF_CLK_I);
    check(CONFIG_ERROR_O, 8'h00);
  endtask
  task automatic final_report();
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge REF_CLK_I);
    RSTN_I = 1;
    for (int k = 1; k < 5; k++) master_frame(k[7:0], 8'hA5 ^ k[7:0]);
    slave_frame(8'h3C, 8'hC6);
    bad_settings();
    final_report();
  end
endmodule
